// File: rtl/utb_regs.vh
// Register map, field positions and reset values of the serial transmit unit
// Operation
// RULE1: Done flag sets when a byte ends: stop bit, or eighth bit in mode 0.
// RULE2: Buffer write with transmitter idle sets done flag at once.
// RULE3: Last byte finishing with nothing queued raises one extra done event.
// RULE4: Queued byte starts straight after the current one, no idle gap.
// RULE5: Ninth bit is read live when its position goes out, never buffered.
// RULE6: Single-buffered use: software clears done flag on entry and after writes.
// RULE7: Bit timing runs at sixteen times the selected baud rate.
// RULE8: Mode 0 baud is osc/16, mode 2 baud is osc/32.
// RULE9: Modes 1 and 3 baud is timer overflow over sixteen, at most osc/64.
// RULE10: Shared two-bit prescale: 00 osc/4, 01 osc/16, 10 osc/64, 11 reserved.
// RULE11: Timer overflow rate is osc over prescale times range minus reload.
// RULE12: Software keeps reload within timer range; impossible rates stay impossible.
// RULE13: Per port and direction, select bits 5 and 4 pick timer 2 overflow.
// RULE14: Timer 2 as baud source is a 16-bit up counter on prescaled ticks.
// RULE15: One port may use timer 2 while the other uses timer 1 or fixed.
// RULE16: With timer 2 selects clear, both ports run from timer 1 overflow.
// RULE17: Buffer write loads transmit; buffer read returns separate receive data.
// RULE18: Mode 1 frame: start 0, eight data bits LSB first, stop 1.
// RULE19: Modes 2 and 3 frame: start, eight data LSB first, ninth bit, stop.
// RULE20: After reset both buffer stages are empty and transmitter idle.
// RULE21: Write while second stage is full overwrites the queued byte.
`ifndef UTB_REGS_VH
`define UTB_REGS_VH

// ****************************************************************
// Register word indices (byte address is four times the index)
// ****************************************************************
`define UTB_T1CTL_IDX   14'h0410
`define UTB_T1RLD_IDX   14'h0411
`define UTB_T2CTL_IDX   14'h0418
`define UTB_TIMER2_MODE_CONTROL_IDX   14'h0419
`define UTB_T2RLD_IDX   14'h041a
`define UTB_SCTL0_IDX   14'h0420
`define UTB_SBUF0_IDX   14'h0421
`define UTB_SCTL1_IDX   14'h0424
`define UTB_SBUF1_IDX   14'h0425
`define UTB_SYSCFG_IDX  14'h0440

// ****************************************************************
// Field positions
// ****************************************************************
`define UTB_T1_RUN_BIT   0
`define UTB_T1_MODE8_BIT 1
`define UTB_T2_RUN_BIT   2
`define UTB_RX_T2_BIT    5
`define UTB_TX_T2_BIT    4
`define UTB_SC_RXDONE    0
`define UTB_SC_TXDONE    1
`define UTB_SC_RX9       2
`define UTB_SC_TX9       3
`define UTB_SC_BUSY      4
`define UTB_SC_MODE_LO   6
`define UTB_PRE_LO_BIT   2
`define UTB_PRE_HI_BIT   3

// ****************************************************************
// Reset values, divisors and frame limits
// ****************************************************************
`define UTB_REG8_RST     8'h00
`define UTB_RLD_RST      16'h0000
`define UTB_PRE_DIV4_M1  6'h03
`define UTB_PRE_DIV16_M1 6'h0f
`define UTB_PRE_DIV64_M1 6'h3f
`define UTB_SUB_LAST     4'hf
`define UTB_SUB_HALF     4'h8
`define UTB_IDX_M0_FIRST 4'h1
`define UTB_IDX_M0_LAST  4'h8
`define UTB_IDX_M1_LAST  4'h9
`define UTB_IDX_M23_LAST 4'ha

`endif

// File: rtl/utb_tx.v
// Double-buffered serial transmitter for one port
`timescale 1ns/1ns
`include "utb_regs.vh"
module utb_tx
#(
	parameter DW = 8
)
(
	input  wire          pclk,
	input  wire          presetn,
	input  wire [1:0]    mode,
	input  wire          tick,
	input  wire          wr,
	input  wire [DW-1:0] wdata,
	input  wire          tx_ninth_bit,
	output reg           txd_q,
	output reg           sdat_q,
	output reg           sdat_oe_q,
	output reg           done_q,
	output reg           busy_q
);

reg [DW-1:0] data_q;
reg [DW-1:0] hold_q;
reg          hold_full_q;
reg [3:0]    idx_q;
reg [3:0]    sub_q;
reg [3:0]    last_idx;
reg [3:0]    first_idx;
reg          bit_val;
wire         bit_end;
wire         frame_end;

// ****************************************************************
// Frame shape
// ****************************************************************
// Frame length by mode; mode 0 has no start or stop bit
always @*
begin
	first_idx = (mode == 2'd0) ? `UTB_IDX_M0_FIRST : 4'h0;
	case (mode)
		2'd0:    last_idx = `UTB_IDX_M0_LAST;
		2'd1:    last_idx = `UTB_IDX_M1_LAST; // RULE18
		default: last_idx = `UTB_IDX_M23_LAST; // RULE19
	endcase
end

// Bit on the line; ninth bit sampled live as it goes out
always @*
begin
	case (idx_q)
		4'h0:    bit_val = 1'b0;
		4'h9:    bit_val = (mode == 2'd1) ? 1'b1 : tx_ninth_bit; // RULE5
		4'ha:    bit_val = 1'b1;
		default: bit_val = data_q[idx_q[2:0] - 3'd1];
	endcase
end

assign bit_end   = busy_q & tick & (sub_q == `UTB_SUB_LAST); // RULE7
assign frame_end = bit_end & (idx_q == last_idx);

// ****************************************************************
// Sequencer and buffer stages
// ****************************************************************
// Reset leaves both stages empty and the line idle
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		busy_q      <= 1'b0; // RULE20
		hold_full_q <= 1'b0;
		data_q      <= {DW{1'b0}};
		hold_q      <= {DW{1'b0}};
		idx_q       <= 4'h0;
		sub_q       <= 4'h0;
		done_q      <= 1'b0;
	end
	else
	begin
		done_q <= frame_end; // RULE1 RULE3
		if (busy_q && tick)
			sub_q <= sub_q + 4'h1;
		if (bit_end && !frame_end)
			idx_q <= idx_q + 4'h1;
		// Queued byte follows with no gap
		if (frame_end)
		begin
			idx_q <= first_idx;
			if (hold_full_q)
			begin
				data_q      <= hold_q; // RULE4
				hold_full_q <= 1'b0;
			end
			else if (!wr)
				busy_q <= 1'b0;
		end
		// Writes either start at once or fill the second stage
		if (wr)
		begin
			if (!busy_q && !hold_full_q)
			begin
				data_q <= wdata;
				busy_q <= 1'b1;
				idx_q  <= first_idx;
				sub_q  <= 4'h0;
				done_q <= 1'b1; // RULE2
			end
			else if (frame_end && !hold_full_q)
				data_q <= wdata; // RULE4
			else
			begin
				hold_q      <= wdata; // RULE21
				hold_full_q <= 1'b1;
			end
		end
	end
end

// ****************************************************************
// Registered line drivers
// ****************************************************************
// Mode 0 puts data on the data pin and the shift clock on txd
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		txd_q     <= 1'b1;
		sdat_q    <= 1'b1;
		sdat_oe_q <= 1'b0;
	end
	else if (busy_q && mode == 2'd0)
	begin
		txd_q     <= (sub_q >= `UTB_SUB_HALF);
		sdat_q    <= bit_val;
		sdat_oe_q <= 1'b1;
	end
	else
	begin
		txd_q     <= busy_q ? bit_val : 1'b1;
		sdat_q    <= 1'b1;
		sdat_oe_q <= 1'b0;
	end
end

endmodule

// File: rtl/utb_top.v
// Two-port serial transmit unit with baud generation and APB registers
`timescale 1ns/1ns
`include "utb_regs.vh"
module utb_top
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [15:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_q,
	output reg         pready_q,
	output reg         pslverr_q,
	input  wire [7:0]  rx_byte0,
	input  wire        rx_bit9_0,
	input  wire        rx_valid0,
	input  wire [7:0]  rx_byte1,
	input  wire        rx_bit9_1,
	input  wire        rx_valid1,
	output wire        txd0_q,
	output wire        sdat0_q,
	output wire        sdat0_oe_q,
	output wire        txd1_q,
	output wire        sdat1_q,
	output wire        sdat1_oe_q,
	output reg         rx_tick0_q,
	output reg         rx_tick1_q
);

// ****************************************************************
// Register storage
// ****************************************************************
reg  [7:0]  t1ctl_q;
reg  [15:0] t1rld_q;
reg  [7:0]  t2ctl_q;
reg  [7:0]  timer2_mode_control_q;
reg  [15:0] t2rld_q;
reg  [7:0]  syscfg_q;
reg  [1:0]  mode0_q;
reg  [1:0]  mode1_q;
reg         tx9_0_q;
reg         tx9_1_q;
reg         txdone0_q;
reg         txdone1_q;
reg         rxdone0_q;
reg         rxdone1_q;
reg         rx9_0_q;
reg         rx9_1_q;
reg  [7:0]  rxbuf0_q;
reg  [7:0]  rxbuf1_q;
reg  [5:0]  pre_q;
reg  [15:0] t1_q;
reg  [15:0] t2_q;
reg         t1_ovf_q;
reg         t2_ovf_q;
reg         half_q;
reg  [5:0]  pre_last;
reg  [31:0] rd_val;
reg         rd_hit;
reg         tick_tx0;
reg         tick_tx1;
reg         tick_rx0_d;
reg         tick_rx1_d;
wire [13:0] widx;
wire        wr_en;
wire        set_up;
wire [1:0]  pre_sel;
wire        tmr_tick;
wire        t1_top;
wire        wr_sbuf0;
wire        wr_sbuf1;
wire        done0;
wire        done1;
wire        busy0;
wire        busy1;

assign widx     = paddr[15:2];
assign set_up   = psel & ~penable;
assign wr_en    = psel & penable & pready_q & pwrite;
assign wr_sbuf0 = wr_en & (widx == `UTB_SBUF0_IDX); // RULE17
assign wr_sbuf1 = wr_en & (widx == `UTB_SBUF1_IDX);
assign pre_sel  = {syscfg_q[`UTB_PRE_HI_BIT], syscfg_q[`UTB_PRE_LO_BIT]};

// ****************************************************************
// Timer tick prescaler and timers
// ****************************************************************
// Prescale divisor; the reserved code stops all timer ticks
always @*
begin
	case (pre_sel)
		2'd0:    pre_last = `UTB_PRE_DIV4_M1; // RULE10
		2'd1:    pre_last = `UTB_PRE_DIV16_M1;
		default: pre_last = `UTB_PRE_DIV64_M1;
	endcase
end

assign tmr_tick = (pre_sel != 2'd3) && (pre_q == pre_last); // RULE10
assign t1_top   = t1ctl_q[`UTB_T1_MODE8_BIT] ? (t1_q[7:0] == 8'hff)
		: (t1_q == 16'hffff);

// Reload on overflow; timer 2 below its reload jumps up, no long first lap
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pre_q    <= 6'h00;
		t1_q     <= `UTB_RLD_RST;
		t2_q     <= `UTB_RLD_RST;
		t1_ovf_q <= 1'b0;
		t2_ovf_q <= 1'b0;
		half_q   <= 1'b0;
	end
	else
	begin
		half_q   <= ~half_q;
		pre_q    <= (tmr_tick || pre_q >= pre_last) ? 6'h00 : pre_q + 6'h01;
		t1_ovf_q <= 1'b0;
		t2_ovf_q <= 1'b0;
		if (tmr_tick && t1ctl_q[`UTB_T1_RUN_BIT])
		begin
			if (t1_top)
			begin
				t1_q     <= t1ctl_q[`UTB_T1_MODE8_BIT]
						? {8'h00, t1rld_q[7:0]} : t1rld_q; // RULE11
				t1_ovf_q <= 1'b1;
			end
			else
				t1_q <= t1_q + 16'h0001;
		end
		if (tmr_tick && t2ctl_q[`UTB_T2_RUN_BIT])
		begin
			if (t2_q == 16'hffff || t2_q < t2rld_q)
			begin
				t2_q     <= t2rld_q; // RULE14 RULE11
				t2_ovf_q <= 1'b1;
			end
			else
				t2_q <= t2_q + 16'h0001;
		end
	end
end

// ****************************************************************
// Per port and direction 16x tick selection
// ****************************************************************
// Timer 2 only where selected, so ports can differ in rate
always @*
begin
	case (mode0_q)
		2'd0:    tick_tx0 = 1'b1; // RULE8
		2'd2:    tick_tx0 = half_q; // RULE8
		default: tick_tx0 = 1'b0;
	endcase
	case (mode1_q)
		2'd0:    tick_tx1 = 1'b1;
		2'd2:    tick_tx1 = half_q;
		default: tick_tx1 = 1'b0;
	endcase
	tick_rx0_d = tick_tx0;
	tick_rx1_d = tick_tx1;
	// Variable-rate modes: overflow is the 16x tick
	if (mode0_q[0])
	begin
		tick_tx0   = t2ctl_q[`UTB_TX_T2_BIT] ? t2_ovf_q : t1_ovf_q; // RULE13
		tick_rx0_d = t2ctl_q[`UTB_RX_T2_BIT] ? t2_ovf_q : t1_ovf_q; // RULE16
	end
	if (mode1_q[0])
	begin
		tick_tx1   = timer2_mode_control_q[`UTB_TX_T2_BIT] ? t2_ovf_q : t1_ovf_q; // RULE15
		tick_rx1_d = timer2_mode_control_q[`UTB_RX_T2_BIT] ? t2_ovf_q : t1_ovf_q; // RULE9
	end
end

// Receive ticks handed to the receivers registered
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		rx_tick0_q <= 1'b0;
		rx_tick1_q <= 1'b0;
	end
	else
	begin
		rx_tick0_q <= tick_rx0_d;
		rx_tick1_q <= tick_rx1_d;
	end
end

// ****************************************************************
// Transmitters
// ****************************************************************
utb_tx #(.DW(8)) u_tx0
(
	.pclk         (pclk),
	.presetn      (presetn),
	.mode         (mode0_q),
	.tick         (tick_tx0),
	.wr           (wr_sbuf0),
	.wdata        (pwdata[7:0]),
	.tx_ninth_bit (tx9_0_q),
	.txd_q        (txd0_q),
	.sdat_q       (sdat0_q),
	.sdat_oe_q    (sdat0_oe_q),
	.done_q       (done0),
	.busy_q       (busy0)
);

utb_tx #(.DW(8)) u_tx1
(
	.pclk         (pclk),
	.presetn      (presetn),
	.mode         (mode1_q),
	.tick         (tick_tx1),
	.wr           (wr_sbuf1),
	.wdata        (pwdata[7:0]),
	.tx_ninth_bit (tx9_1_q),
	.txd_q        (txd1_q),
	.sdat_q       (sdat1_q),
	.sdat_oe_q    (sdat1_oe_q),
	.done_q       (done1),
	.busy_q       (busy1)
);

// ****************************************************************
// APB writes and flags
// ****************************************************************
// Hardware set beats a software clear in the same cycle
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		t1ctl_q   <= `UTB_REG8_RST;
		t1rld_q   <= `UTB_RLD_RST;
		t2ctl_q   <= `UTB_REG8_RST;
		timer2_mode_control_q   <= `UTB_REG8_RST;
		t2rld_q   <= `UTB_RLD_RST;
		syscfg_q  <= `UTB_REG8_RST;
		mode0_q   <= 2'd0;
		mode1_q   <= 2'd0;
		tx9_0_q   <= 1'b0;
		tx9_1_q   <= 1'b0;
		txdone0_q <= 1'b0;
		txdone1_q <= 1'b0;
		rxdone0_q <= 1'b0;
		rxdone1_q <= 1'b0;
		rx9_0_q   <= 1'b0;
		rx9_1_q   <= 1'b0;
		rxbuf0_q  <= 8'h00;
		rxbuf1_q  <= 8'h00;
	end
	else
	begin
		if (wr_en)
		begin
			case (widx)
				`UTB_T1CTL_IDX:  t1ctl_q  <= pwdata[7:0];
				`UTB_T1RLD_IDX:  t1rld_q  <= pwdata[15:0];
				`UTB_T2CTL_IDX:  t2ctl_q  <= pwdata[7:0];
				`UTB_TIMER2_MODE_CONTROL_IDX:  timer2_mode_control_q  <= pwdata[7:0];
				`UTB_T2RLD_IDX:  t2rld_q  <= pwdata[15:0];
				`UTB_SYSCFG_IDX: syscfg_q <= pwdata[7:0];
				`UTB_SCTL0_IDX:
				begin
					mode0_q   <= pwdata[`UTB_SC_MODE_LO+1:`UTB_SC_MODE_LO];
					tx9_0_q   <= pwdata[`UTB_SC_TX9];
					txdone0_q <= pwdata[`UTB_SC_TXDONE];
					rxdone0_q <= pwdata[`UTB_SC_RXDONE];
				end
				`UTB_SCTL1_IDX:
				begin
					mode1_q   <= pwdata[`UTB_SC_MODE_LO+1:`UTB_SC_MODE_LO];
					tx9_1_q   <= pwdata[`UTB_SC_TX9];
					txdone1_q <= pwdata[`UTB_SC_TXDONE];
					rxdone1_q <= pwdata[`UTB_SC_RXDONE];
				end
				default: ;
			endcase
		end
		if (done0)
			txdone0_q <= 1'b1; // RULE1 RULE2
		if (done1)
			txdone1_q <= 1'b1; // RULE1 RULE2
		// Separate receive holding registers
		if (rx_valid0)
		begin
			rxbuf0_q  <= rx_byte0; // RULE17
			rx9_0_q   <= rx_bit9_0;
			rxdone0_q <= 1'b1;
		end
		if (rx_valid1)
		begin
			rxbuf1_q  <= rx_byte1;
			rx9_1_q   <= rx_bit9_1;
			rxdone1_q <= 1'b1;
		end
	end
end

// ****************************************************************
// APB read path
// ****************************************************************
// Read mux; unmapped words read zero with an error answer
always @*
begin
	rd_val = 32'h0000_0000;
	rd_hit = 1'b1;
	case (widx)
		`UTB_T1CTL_IDX:  rd_val[7:0]  = t1ctl_q;
		`UTB_T1RLD_IDX:  rd_val[15:0] = t1rld_q;
		`UTB_T2CTL_IDX:  rd_val[7:0]  = t2ctl_q;
		`UTB_TIMER2_MODE_CONTROL_IDX:  rd_val[7:0]  = timer2_mode_control_q;
		`UTB_T2RLD_IDX:  rd_val[15:0] = t2rld_q;
		`UTB_SYSCFG_IDX: rd_val[7:0]  = syscfg_q;
		`UTB_SCTL0_IDX:  rd_val[7:0]  = {mode0_q, 1'b0, busy0, tx9_0_q,
				rx9_0_q, txdone0_q, rxdone0_q};
		`UTB_SCTL1_IDX:  rd_val[7:0]  = {mode1_q, 1'b0, busy1, tx9_1_q,
				rx9_1_q, txdone1_q, rxdone1_q};
		`UTB_SBUF0_IDX:  rd_val[7:0]  = rxbuf0_q; // RULE17
		`UTB_SBUF1_IDX:  rd_val[7:0]  = rxbuf1_q;
		default:         rd_hit       = 1'b0;
	endcase
end

// Answer is prepared in the setup cycle, so every access has one cycle
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		prdata_q  <= 32'h0000_0000;
		pready_q  <= 1'b0;
		pslverr_q <= 1'b0;
	end
	else
	begin
		pready_q  <= set_up;
		pslverr_q <= set_up & ~rd_hit;
		if (set_up && !pwrite)
			prdata_q <= rd_val;
	end
end

endmodule

// File: tb/utb_top_properties.sv
// Port assertions for the two-port serial transmit unit
`timescale 1ns/1ns
`include "utb_regs.vh"
module utb_top_properties
(
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [15:0] paddr,
	input wire [31:0] prdata_q,
	input wire        pready_q,
	input wire        pslverr_q,
	input wire        txd0_q,
	input wire        sdat0_q,
	input wire        sdat0_oe_q,
	input wire        txd1_q
);
	// Decode of mapped words, to judge the error answer
	wire hit;
	assign hit = paddr[15:2] inside {`UTB_T1CTL_IDX, `UTB_T1RLD_IDX,
		`UTB_T2CTL_IDX, `UTB_TIMER2_MODE_CONTROL_IDX, `UTB_T2RLD_IDX, `UTB_SCTL0_IDX,
		`UTB_SBUF0_IDX, `UTB_SCTL1_IDX, `UTB_SBUF1_IDX, `UTB_SYSCFG_IDX};

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ****************************************************************
	// Bus answer
	// ****************************************************************
	property p_ready_access;
		psel && !penable |=> pready_q && penable;
	endproperty
	a_ready_access: assert property (p_ready_access)
		else $error("ready missing in access cycle");
	property p_ready_pulse;
		pready_q |=> !pready_q;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready longer than one cycle");
	property p_err_decode;
		psel && !penable && paddr[1:0] == 2'b00 |=> pslverr_q == !$past(hit);
	endproperty
	a_err_decode: assert property (p_err_decode)
		else $error("error answer does not match decode");
	property p_err_zero;
		pslverr_q && !pwrite |-> prdata_q == 32'h0 && pready_q;
	endproperty
	a_err_zero: assert property (p_err_zero)
		else $error("refused read returned data");
	property p_upper_zero;
		pready_q && !pwrite |-> prdata_q[31:16] == 16'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper read bits not zero");

	// ****************************************************************
	// Serial lines
	// ****************************************************************
	// Mode 0 bit: shift clock low half then high half, 16 cycles
	sequence s_clk_lo;
		!txd0_q [*8];
	endsequence
	sequence s_clk_hi;
		txd0_q [*8];
	endsequence
	property p_reset_idle;
		$rose(presetn) |-> txd0_q && txd1_q && !sdat0_oe_q;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("lines not idle after reset");
	property p_m0_bit;
		$rose(sdat0_oe_q) |-> s_clk_lo ##1 s_clk_hi;
	endproperty
	a_m0_bit: assert property (p_m0_bit)
		else $error("shift clock period wrong");
	property p_m0_data;
		sdat0_oe_q && $past(sdat0_oe_q) && $changed(sdat0_q) |-> $fell(txd0_q);
	endproperty
	a_m0_data: assert property (p_m0_data)
		else $error("shift data moved inside a bit");
	property p_start0;
		$fell(txd0_q) |-> !txd0_q [*8];
	endproperty
	a_start0: assert property (p_start0)
		else $error("port 0 low level too short");
	property p_start1;
		$fell(txd1_q) |-> !txd1_q [*8];
	endproperty
	a_start1: assert property (p_start1)
		else $error("port 1 low level too short");
endmodule

bind utb_top utb_top_properties u_prop (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
	.txd0_q(txd0_q), .sdat0_q(sdat0_q), .sdat0_oe_q(sdat0_oe_q),
	.txd1_q(txd1_q));

// File: tb/utb_partner.sv
// Far-end serial device: frame decoder and receive byte source
`timescale 1ns/1ns
module utb_partner
(
	input  wire        pclk,
	input  wire        txd,
	input  wire        sdat,
	input  wire        sdat_oe,
	input  wire [15:0] bitc,
	input  wire [3:0]  nbits,
	output reg  [7:0]  rx_byte,
	output reg         rx_bit9,
	output reg         rx_valid
);
	int          cnt = 0;
	int          cyc = 0;
	int          t0 [0:31];
	logic [8:0]  got [0:31];
	logic [10:0] sh;
	logic        bad = 1'b0;

	initial
	begin
		rx_byte = 8'h00;
		rx_bit9 = 1'b0;
		rx_valid = 1'b0;
	end

	// Cycle stamp for frame start times
	always @(posedge pclk)
		cyc <= cyc + 1;

	// Decoder: shift clock frames when data pin driven, else UART
	always
	begin
		@(negedge txd);
		#1;
		t0[cnt] = cyc;
		sh = 11'h0;
		if (sdat_oe)
		begin
			for (int i = 0; i < 8; i++)
			begin
				@(posedge txd);
				sh[i + 1] = sdat;
			end
		end
		else
		begin
			// Mid-bit sampling; no wait after the stop sample
			repeat (bitc / 2) @(posedge pclk);
			for (int i = 0; i < nbits; i++)
			begin
				sh[i] = txd;
				if (i < nbits - 1)
					repeat (bitc) @(posedge pclk);
			end
			bad = bad | sh[0] | ~sh[nbits - 1];
		end
		got[cnt] = {(nbits == 4'd11) ? sh[9] : 1'b0, sh[8:1]};
		cnt++;
	end

	// Received byte handed over as a one-cycle pulse
	task automatic send(input logic [7:0] b, input logic n9);
		@(posedge pclk);
		rx_byte <= b;
		rx_bit9 <= n9;
		rx_valid <= 1'b1;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
		rx_bit9 <= ~n9;
	endtask
endmodule

// File: tb/test_utb_top.sv
// Self-checking bench for the two-port serial transmit unit
`timescale 1ns/1ns
`include "utb_regs.vh"
module test_utb_top;
	localparam [15:0] T1C = {`UTB_T1CTL_IDX, 2'b00};
	localparam [15:0] T1R = {`UTB_T1RLD_IDX, 2'b00};
	localparam [15:0] T2C = {`UTB_T2CTL_IDX, 2'b00};
	localparam [15:0] T2R = {`UTB_T2RLD_IDX, 2'b00};
	localparam [15:0] T2M = {`UTB_TIMER2_MODE_CONTROL_IDX, 2'b00};
	localparam [15:0] SC0 = {`UTB_SCTL0_IDX, 2'b00};
	localparam [15:0] SB0 = {`UTB_SBUF0_IDX, 2'b00};
	localparam [15:0] SC1 = {`UTB_SCTL1_IDX, 2'b00};
	localparam [15:0] SB1 = {`UTB_SBUF1_IDX, 2'b00};
	localparam [15:0] SYS = {`UTB_SYSCFG_IDX, 2'b00};
	reg          pclk = 1'b0;
	reg          presetn = 1'b0;
	reg          psel = 1'b0;
	reg          penable = 1'b0;
	reg          pwrite = 1'b0;
	reg   [15:0] paddr = 16'h0;
	reg   [31:0] pwdata = 32'h0;
	reg   [15:0] bitc = 16'd16;
	reg   [3:0]  nb = 4'd10;
	wire  [31:0] prdata_q;
	wire         pready_q, pslverr_q, txd0_q, sdat0_q, sdat0_oe_q;
	wire         txd1_q, sdat1_q, sdat1_oe_q, rxv0, rxn0, rxv1, rxn1;
	wire         rxt0, rxt1;
	wire  [7:0]  rxb0, rxb1;
	logic [31:0] rdv;
	logic        err;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          k = 0;
	int          j = 0;

	always #5 pclk = ~pclk;

	utb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.rx_byte0(rxb0), .rx_bit9_0(rxn0), .rx_valid0(rxv0),
		.rx_byte1(rxb1), .rx_bit9_1(rxn1), .rx_valid1(rxv1),
		.txd0_q(txd0_q), .sdat0_q(sdat0_q), .sdat0_oe_q(sdat0_oe_q),
		.txd1_q(txd1_q), .sdat1_q(sdat1_q), .sdat1_oe_q(sdat1_oe_q),
		.rx_tick0_q(rxt0), .rx_tick1_q(rxt1));
	utb_partner prt0 (.pclk(pclk), .txd(txd0_q), .sdat(sdat0_q),
		.sdat_oe(sdat0_oe_q), .bitc(bitc), .nbits(nb), .rx_byte(rxb0),
		.rx_bit9(rxn0), .rx_valid(rxv0));
	utb_partner prt1 (.pclk(pclk), .txd(txd1_q), .sdat(sdat1_q),
		.sdat_oe(sdat1_oe_q), .bitc(bitc), .nbits(nb), .rx_byte(rxb1),
		.rx_bit9(rxn1), .rx_valid(rxv1));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	// APB transfer: setup, then hold access until pready is sampled
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		repeat (50) if (pready_q !== 1'b1) @(posedge pclk);
		chk(pready_q, 1'b1);
		rdv = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Wait for n decoded frames, then one more bit so the line settles
	task automatic wait_rx(input int p, input int n);
		repeat (30000) if ((p ? prt1.cnt : prt0.cnt) < n) @(posedge pclk);
		chk(p ? prt1.cnt : prt0.cnt, n);
		repeat (bitc) @(posedge pclk);
	endtask

	task automatic wrap_up;
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog: far beyond the roughly 25000 cycles of the tests
	initial
	begin
		#600000;
		error_cnt++;
		wrap_up;
	end

	// Main sequence
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, SC0, 0);
		chk(rdv, 32'h0);
		apb(1, T1R, 32'hff);
		apb(0, T1R, 0);
		chk(rdv, 32'hff);
		apb(1, T1C, 32'h3);
		apb(0, 16'h0ffc, 0);
		chk(err, 1'b1);
		chk(rdv, 32'h0);
		// Mode 0 shift frame
		apb(1, SB0, 32'ha5);
		apb(0, SC0, 0);
		chk(rdv & 32'h12, 32'h12);
		apb(1, SC0, 32'h0);
		wait_rx(0, 1);
		chk(prt0.got[0], 9'h0a5);
		apb(0, SC0, 0);
		chk(rdv & 32'h2, 32'h2);
		// Mode 1 on timer 1, queued byte overwritten once
		repeat (900) @(posedge pclk);
		bitc = 16'd64;
		apb(1, SC0, 32'h40);
		// Receive ticks: port 0 on timer 1 at osc/4, port 1 still mode 0
		repeat (64)
		begin
			@(posedge pclk);
			k += rxt0;
			j += rxt1;
		end
		chk(k, 16);
		chk(j, 64);
		apb(1, SB0, 32'h3c);
		apb(1, SC0, 32'h40);
		apb(1, SB0, 32'h11);
		apb(1, SB0, 32'hc3);
		apb(0, SC0, 0);
		chk(rdv & 32'h12, 32'h10);
		wait_rx(0, 2);
		chk(prt0.got[1], 9'h03c);
		apb(0, SC0, 0);
		chk(rdv & 32'h2, 32'h2);
		apb(1, SC0, 32'h40);
		wait_rx(0, 3);
		chk(prt0.got[2], 9'h0c3);
		// First start bit is cut to the tick phase; count whole ticks
		chk((prt0.t0[2] - prt0.t0[1] + 3) / 4, 160);
		apb(0, SC0, 0);
		chk(rdv & 32'h12, 32'h2);
		// Mode 2: ninth bit changed while the frame is going out
		nb = 4'd11;
		bitc = 16'd32;
		for (int i = 0; i < 2; i++)
		begin
			apb(1, SC0, 32'h88);
			apb(1, SB0, i ? 32'h97 : 32'h96);
			apb(1, SC0, i ? 32'h88 : 32'h80);
			wait_rx(0, 4 + i);
			chk(prt0.got[3 + i], i ? 9'h197 : 9'h096);
		end
		// Mode 3 at each usable prescale code
		for (int c = 0; c < 3; c++)
		begin
			apb(1, SYS, c << 2);
			bitc = 16'd64 << (2 * c);
			apb(1, SC0, 32'hc8);
			apb(1, SB0, 32'h55 + c);
			wait_rx(0, 6 + c);
			chk(prt0.got[5 + c], 9'h155 + c);
		end
		// Receive buffer is separate from the transmit load
		prt0.send(8'h6e, 1'b1);
		apb(0, SB0, 0);
		chk(rdv, 32'h6e);
		apb(0, SC0, 0);
		chk(rdv & 32'h5, 32'h5);
		// Port 1 on timer 1 by default, then moved to stopped timer 2
		apb(1, SYS, 32'h0);
		bitc = 16'd64;
		apb(1, SC1, 32'hc0);
		apb(1, SB1, 32'h81);
		wait_rx(1, 1);
		chk(prt1.got[0], 9'h081);
		chk(prt0.bad | prt1.bad, 1'b0);
		apb(1, T2M, 32'h10);
		apb(0, T2M, 0);
		chk(rdv, 32'h10);
		apb(1, SB1, 32'h42);
		apb(1, SB0, 32'h24);
		wait_rx(0, 9);
		chk(prt0.got[8], 9'h124);
		apb(0, SC1, 0);
		chk(rdv & 32'h10, 32'h10);
		// Port 0 moved to timer 2 with timer 1 stopped
		apb(1, T1C, 32'h0);
		apb(1, T2R, 32'hffff);
		apb(1, T2C, 32'h14);
		apb(1, SB0, 32'h5a);
		wait_rx(0, 10);
		chk(prt0.got[9], 9'h15a);
		// Reserved prescale code gives no timer ticks
		apb(1, SYS, 32'hc);
		apb(1, SB0, 32'h33);
		repeat (1500) @(posedge pclk);
		apb(0, SC0, 0);
		chk(rdv & 32'h10, 32'h10);
		wrap_up;
	end
endmodule
